// [design/amdc_pkg.sv]
package amdc_pkg;
   // register bus geometry
   localparam int ADDR_W = 8;
   localparam int REG_W  = 8;

   // register offsets
   localparam logic [7:0] AUTO_MUTE_CONTROL_ADDR           = 8'h41;
   localparam logic [7:0] PRIMARY_DITHER_GAINS_ADDR        = 8'h43;
   localparam logic [7:0] LEFT_PRIMARY_DC_DITHER_HIGH_ADDR = 8'h44;
   localparam logic [7:0] LEFT_PRIMARY_DC_DITHER_LOW_ADDR  = 8'h45;
   localparam logic [7:0] RIGHT_PRIMARY_DC_DITHER_PART_ADDR = 8'h46;

   // reset values
   localparam logic [7:0] AUTO_MUTE_CONTROL_RST           = 8'h07;
   localparam logic [7:0] PRIMARY_DITHER_GAINS_RST        = 8'h00;
   localparam logic [7:0] LEFT_PRIMARY_DC_DITHER_HIGH_RST = 8'h00;
   localparam logic [7:0] LEFT_PRIMARY_DC_DITHER_LOW_RST  = 8'h00;
   localparam logic [7:0] RIGHT_PRIMARY_DC_DITHER_PART_RST = 8'h00;
   localparam logic [7:0] UNMAPPED_READ_VALUE             = 8'h00;

   // auto mute control bit positions
   localparam int AUTO_MUTE_LINK_BIT        = 2;
   localparam int AUTO_MUTE_BIT1_ENABLE_BIT = 1;
   localparam int AUTO_MUTE_BIT0_ENABLE_BIT = 0;

   // dither gain field positions (low bit of each 2-bit field)
   localparam int GAIN_FIELD_W                    = 2;
   localparam int LEFT_PRIMARY_AC_DITHER_GAIN_LSB = 6;
   localparam int RIGHT_PRIMARY_AC_DITHER_GAIN_LSB = 4;
   localparam int LEFT_PRIMARY_DEM_DITHER_GAIN_LSB = 2;
   localparam int RIGHT_PRIMARY_DEM_DITHER_GAIN_LSB = 0;

   // gain codes
   localparam logic [1:0] AC_GAIN_0P125_CODE = 2'h0;
   localparam logic [1:0] AC_GAIN_0P25_CODE  = 2'h1;
   localparam logic [1:0] DEM_GAIN_0P5_CODE  = 2'h0;
   localparam logic [1:0] DEM_GAIN_1P0_CODE  = 2'h1;

   // dc dither, q0.11, 1.0 = 1/32 of modulator full scale
   localparam int DC_DITHER_W      = 11;
   localparam int DC_DITHER_HIGH_W = 3;
   localparam int DC_DITHER_LOW_W  = 8;
   localparam logic [10:0] DC_DITHER_NONE = 11'h000;
endpackage

// [design/amdc_config.sv]
`timescale 1ns/1ps
//Function
// - With the link bit clear, each channel auto mutes on its own detection.
// - With the link bit set, neither channel mutes until both qualify, then both mute together.
// - Bit 1 is the auto mute enable of the right channel, 0 off and 1 on.
// - With right auto mute off and the link bit set, the left channel never auto mutes.
// - Bit 0 is the auto mute enable of the left channel, 0 off and 1 on.
// - With left auto mute off and the link bit set, the right channel never auto mutes.
// - Auto mute is triggered by zero samples lasting the separately configured length.
// - Left primary ac dither gain in bits 7-6 selects 0.125 for 00 and 0.25 for 01.
// - Right primary ac dither gain in bits 5-4 selects 0.125 for 00 and 0.25 for 01.
// - Left primary dem dither gain in bits 3-2 selects 0.5 for 00 and 1.0 for 01.
// - Right primary dem dither gain in bits 1-0 selects 0.5 for 00 and 1.0 for 01.
// - The left dc dither value is added to the lower part of the left modulator.
// - The right dc dither value is added to the lower part of the right modulator.
// - A zero dc dither code adds nothing and each lsb is one step of the lower part.
module amdc_config
#(
   parameter int MOD_W = 16
)
(
   input  wire logic                                 i_ref_clk,
   input  wire logic                                 i_nrst,
   input  wire logic [amdc_pkg::ADDR_W-1:0]          i_reg_addr,
   input  wire logic                                 i_reg_wr,
   input  wire logic                                 i_reg_rd,
   input  wire logic [amdc_pkg::REG_W-1:0]           i_reg_wdata,
   output logic      [amdc_pkg::REG_W-1:0]           o_reg_rdata,
   input  wire logic                                 i_left_zero_qualified,
   input  wire logic                                 i_right_zero_qualified,
   output logic                                      o_left_auto_mute,
   output logic                                      o_right_auto_mute,
   output logic      [amdc_pkg::GAIN_FIELD_W-1:0]    o_left_primary_ac_dither_gain,
   output logic      [amdc_pkg::GAIN_FIELD_W-1:0]    o_right_primary_ac_dither_gain,
   output logic      [amdc_pkg::GAIN_FIELD_W-1:0]    o_left_primary_dem_dither_gain,
   output logic      [amdc_pkg::GAIN_FIELD_W-1:0]    o_right_primary_dem_dither_gain,
   input  wire logic [amdc_pkg::DC_DITHER_HIGH_W-1:0] i_right_dc_dither_high,
   output logic      [amdc_pkg::DC_DITHER_W-1:0]     o_left_primary_dc_dither,
   output logic      [amdc_pkg::DC_DITHER_W-1:0]     o_right_primary_dc_dither,
   input  wire logic [MOD_W-1:0]                     i_left_mod_lower,
   input  wire logic [MOD_W-1:0]                     i_right_mod_lower,
   output logic      [MOD_W-1:0]                     o_left_mod_lower_dithered,
   output logic      [MOD_W-1:0]                     o_right_mod_lower_dithered
);
   import amdc_pkg::*;

   logic [REG_W-1:0]       auto_mute_control;
   logic [REG_W-1:0]       primary_dither_gains;
   logic [REG_W-1:0]       left_primary_dc_dither_high;
   logic [REG_W-1:0]       left_primary_dc_dither_low;
   logic [REG_W-1:0]       right_primary_dc_dither_part;
   logic                   auto_mute_link;
   logic                   auto_mute_bit1_enable;
   logic                   auto_mute_bit0_enable;
   logic                   left_qualifies;
   logic                   right_qualifies;
   logic                   next_left_auto_mute;
   logic                   next_right_auto_mute;
   logic [DC_DITHER_W-1:0] left_primary_dc_dither;
   logic [DC_DITHER_W-1:0] right_primary_dc_dither;
   logic [REG_W-1:0]       next_rdata;

   // register writes, reserved bits kept as written
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         auto_mute_control            <= AUTO_MUTE_CONTROL_RST;
         primary_dither_gains         <= PRIMARY_DITHER_GAINS_RST;
         left_primary_dc_dither_high  <= LEFT_PRIMARY_DC_DITHER_HIGH_RST;
         left_primary_dc_dither_low   <= LEFT_PRIMARY_DC_DITHER_LOW_RST;
         right_primary_dc_dither_part <= RIGHT_PRIMARY_DC_DITHER_PART_RST;
      end
      else if (i_reg_wr)
      begin
         if (i_reg_addr == AUTO_MUTE_CONTROL_ADDR)
         begin
            auto_mute_control <= i_reg_wdata;
         end
         else if (i_reg_addr == PRIMARY_DITHER_GAINS_ADDR)
         begin
            primary_dither_gains <= i_reg_wdata;
         end
         else if (i_reg_addr == LEFT_PRIMARY_DC_DITHER_HIGH_ADDR)
         begin
            left_primary_dc_dither_high <= i_reg_wdata;
         end
         else if (i_reg_addr == LEFT_PRIMARY_DC_DITHER_LOW_ADDR)
         begin
            left_primary_dc_dither_low <= i_reg_wdata;
         end
         else if (i_reg_addr == RIGHT_PRIMARY_DC_DITHER_PART_ADDR)
         begin
            right_primary_dc_dither_part <= i_reg_wdata;
         end
      end
   end

   // read decode, unmapped offsets read zero
   always_comb
   begin
      next_rdata = UNMAPPED_READ_VALUE;
      if (i_reg_addr == AUTO_MUTE_CONTROL_ADDR)
      begin
         next_rdata = auto_mute_control;
      end
      else if (i_reg_addr == PRIMARY_DITHER_GAINS_ADDR)
      begin
         next_rdata = primary_dither_gains;
      end
      else if (i_reg_addr == LEFT_PRIMARY_DC_DITHER_HIGH_ADDR)
      begin
         next_rdata = left_primary_dc_dither_high;
      end
      else if (i_reg_addr == LEFT_PRIMARY_DC_DITHER_LOW_ADDR)
      begin
         next_rdata = left_primary_dc_dither_low;
      end
      else if (i_reg_addr == RIGHT_PRIMARY_DC_DITHER_PART_ADDR)
      begin
         next_rdata = right_primary_dc_dither_part;
      end
   end

   // read data register, held until the next read
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_reg_rdata <= UNMAPPED_READ_VALUE;
      end
      else if (i_reg_rd)
      begin
         o_reg_rdata <= next_rdata;
      end
   end

   // auto mute control fields
   assign auto_mute_link        = auto_mute_control[AUTO_MUTE_LINK_BIT];
   assign auto_mute_bit1_enable = auto_mute_control[AUTO_MUTE_BIT1_ENABLE_BIT];
   assign auto_mute_bit0_enable = auto_mute_control[AUTO_MUTE_BIT0_ENABLE_BIT];

   // per-channel qualification from the zero detector
   assign left_qualifies  = auto_mute_bit0_enable & i_left_zero_qualified;
   assign right_qualifies = auto_mute_bit1_enable & i_right_zero_qualified;

   // independent or linked mute decision
   always_comb
   begin
      if (auto_mute_link)
      begin
         next_left_auto_mute  = left_qualifies & right_qualifies;
         next_right_auto_mute = left_qualifies & right_qualifies;
      end
      else
      begin
         next_left_auto_mute  = left_qualifies;
         next_right_auto_mute = right_qualifies;
      end
   end

   // mute outputs
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_left_auto_mute  <= 1'b0;
         o_right_auto_mute <= 1'b0;
      end
      else
      begin
         o_left_auto_mute  <= next_left_auto_mute;
         o_right_auto_mute <= next_right_auto_mute;
      end
   end

   // gain field outputs
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_left_primary_ac_dither_gain   <= AC_GAIN_0P125_CODE;
         o_right_primary_ac_dither_gain  <= AC_GAIN_0P125_CODE;
         o_left_primary_dem_dither_gain  <= DEM_GAIN_0P5_CODE;
         o_right_primary_dem_dither_gain <= DEM_GAIN_0P5_CODE;
      end
      else
      begin
         o_left_primary_ac_dither_gain <=
            primary_dither_gains[LEFT_PRIMARY_AC_DITHER_GAIN_LSB +: GAIN_FIELD_W];
         o_right_primary_ac_dither_gain <=
            primary_dither_gains[RIGHT_PRIMARY_AC_DITHER_GAIN_LSB +: GAIN_FIELD_W];
         o_left_primary_dem_dither_gain <=
            primary_dither_gains[LEFT_PRIMARY_DEM_DITHER_GAIN_LSB +: GAIN_FIELD_W];
         o_right_primary_dem_dither_gain <=
            primary_dither_gains[RIGHT_PRIMARY_DEM_DITHER_GAIN_LSB +: GAIN_FIELD_W];
      end
   end

   // assemble the 11-bit dc dither words
   assign left_primary_dc_dither  = {left_primary_dc_dither_high[DC_DITHER_HIGH_W-1:0],
                                     left_primary_dc_dither_low};
   assign right_primary_dc_dither = {i_right_dc_dither_high,
                                     right_primary_dc_dither_part};

   // dc dither add into the modulator lower part, wraps at MOD_W
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_left_primary_dc_dither   <= DC_DITHER_NONE;
         o_right_primary_dc_dither  <= DC_DITHER_NONE;
         o_left_mod_lower_dithered  <= '0;
         o_right_mod_lower_dithered <= '0;
      end
      else
      begin
         o_left_primary_dc_dither   <= left_primary_dc_dither;
         o_right_primary_dc_dither  <= right_primary_dc_dither;
         o_left_mod_lower_dithered  <=
            MOD_W'(i_left_mod_lower + MOD_W'(left_primary_dc_dither));
         o_right_mod_lower_dithered <=
            MOD_W'(i_right_mod_lower + MOD_W'(right_primary_dc_dither));
      end
   end

   // checks
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_nrst);

   sequence s_write_ctrl_link_clear;
      i_reg_wr && i_reg_addr == AUTO_MUTE_CONTROL_ADDR
         && !i_reg_wdata[AUTO_MUTE_LINK_BIT];
   endsequence

   sequence s_both_qualify_linked;
      auto_mute_link && left_qualifies && right_qualifies;
   endsequence

   property p_independent_left;
      !auto_mute_link |=> o_left_auto_mute == $past(left_qualifies);
   endproperty
   a_independent_left: assert property (p_independent_left)
      else $error("left mute not independent");

   property p_linked_together;
      auto_mute_link |=> o_left_auto_mute == o_right_auto_mute;
   endproperty
   a_linked_together: assert property (p_linked_together)
      else $error("linked channels mute apart");

   property p_linked_both;
      s_both_qualify_linked |=> o_left_auto_mute && o_right_auto_mute;
   endproperty
   a_linked_both: assert property (p_linked_both)
      else $error("linked mute missing");

   property p_right_off_left_never;
      auto_mute_link && !auto_mute_bit1_enable |=> !o_left_auto_mute;
   endproperty
   a_right_off_left_never: assert property (p_right_off_left_never)
      else $error("left muted with right disabled");

   property p_left_off_right_never;
      auto_mute_link && !auto_mute_bit0_enable |=> !o_right_auto_mute;
   endproperty
   a_left_off_right_never: assert property (p_left_off_right_never)
      else $error("right muted with left disabled");

   property p_right_enable;
      !auto_mute_bit1_enable |=> !o_right_auto_mute;
   endproperty
   a_right_enable: assert property (p_right_enable)
      else $error("right muted while disabled");

   property p_zero_needed;
      !i_left_zero_qualified |=> !o_left_auto_mute;
   endproperty
   a_zero_needed: assert property (p_zero_needed)
      else $error("left muted without zero detection");

   property p_write_then_independent;
      s_write_ctrl_link_clear ##1 (left_qualifies && !right_qualifies)
         |=> o_left_auto_mute && !o_right_auto_mute;
   endproperty
   a_write_then_independent: assert property (p_write_then_independent)
      else $error("link clear write not honoured");

   property p_gain_write;
      i_reg_wr && i_reg_addr == PRIMARY_DITHER_GAINS_ADDR
         |-> ##2 o_left_primary_ac_dither_gain == $past(i_reg_wdata[7:6], 2)
            && o_right_primary_dem_dither_gain == $past(i_reg_wdata[1:0], 2);
   endproperty
   a_gain_write: assert property (p_gain_write)
      else $error("gain fields wrong after write");

   property p_left_dc_add;
      1'b1 |=> o_left_mod_lower_dithered
         == MOD_W'($past(i_left_mod_lower) + MOD_W'($past(left_primary_dc_dither)));
   endproperty
   a_left_dc_add: assert property (p_left_dc_add)
      else $error("left dc dither sum wrong");

   property p_zero_dither;
      right_primary_dc_dither == DC_DITHER_NONE
         |=> o_right_mod_lower_dithered == $past(i_right_mod_lower);
   endproperty
   a_zero_dither: assert property (p_zero_dither)
      else $error("zero dither changed sample");

   property p_left_dc_assembly;
      i_reg_wr && i_reg_addr == LEFT_PRIMARY_DC_DITHER_LOW_ADDR
         |-> ##2 o_left_primary_dc_dither[7:0] == $past(i_reg_wdata, 2);
   endproperty
   a_left_dc_assembly: assert property (p_left_dc_assembly)
      else $error("left dc low byte wrong");

   property p_left_enable;
      !auto_mute_bit0_enable |=> !o_left_auto_mute;
   endproperty
   a_left_enable: assert property (p_left_enable)
      else $error("left muted while disabled");

   property p_gain_write_mid;
      i_reg_wr && i_reg_addr == PRIMARY_DITHER_GAINS_ADDR
         |-> ##2 o_right_primary_ac_dither_gain
               == $past(i_reg_wdata[RIGHT_PRIMARY_AC_DITHER_GAIN_LSB +: GAIN_FIELD_W], 2)
            && o_left_primary_dem_dither_gain
               == $past(i_reg_wdata[LEFT_PRIMARY_DEM_DITHER_GAIN_LSB +: GAIN_FIELD_W], 2);
   endproperty
   a_gain_write_mid: assert property (p_gain_write_mid)
      else $error("middle gain fields wrong after write");

   property p_right_dc_add;
      1'b1 |=> o_right_mod_lower_dithered
         == MOD_W'($past(i_right_mod_lower) + MOD_W'($past(right_primary_dc_dither)));
   endproperty
   a_right_dc_add: assert property (p_right_dc_add)
      else $error("right dc dither sum wrong");

   property p_right_dc_assembly;
      1'b1 |=> o_right_primary_dc_dither
         == {$past(i_right_dc_dither_high), $past(right_primary_dc_dither_part)};
   endproperty
   a_right_dc_assembly: assert property (p_right_dc_assembly)
      else $error("right dc word wrong");

endmodule // amdc_config

// [design/amdc_dummy_unused.sv]
`timescale 1ns/1ps

// [sim/amdc_config_tb.sv]
`timescale 1ns/1ps
module amdc_config_tb;
   import amdc_pkg::*;

   localparam int MOD_W      = 16;
   localparam int MAX_CYCLES = 6000;

   logic                      i_ref_clk              = 1'b0;
   logic                      i_nrst                 = 1'b0;
   logic [ADDR_W-1:0]         i_reg_addr             = 8'h00;
   logic                      i_reg_wr               = 1'b0;
   logic                      i_reg_rd               = 1'b0;
   logic [REG_W-1:0]          i_reg_wdata            = 8'h00;
   logic                      i_left_zero_qualified  = 1'b0;
   logic                      i_right_zero_qualified = 1'b0;
   logic [DC_DITHER_HIGH_W-1:0] i_right_dc_dither_high = 3'h0;
   logic [MOD_W-1:0]          i_left_mod_lower       = 16'h0000;
   logic [MOD_W-1:0]          i_right_mod_lower      = 16'h0000;
   logic [REG_W-1:0]          o_reg_rdata;
   logic                      o_left_auto_mute;
   logic                      o_right_auto_mute;
   logic [GAIN_FIELD_W-1:0]   o_left_primary_ac_dither_gain;
   logic [GAIN_FIELD_W-1:0]   o_right_primary_ac_dither_gain;
   logic [GAIN_FIELD_W-1:0]   o_left_primary_dem_dither_gain;
   logic [GAIN_FIELD_W-1:0]   o_right_primary_dem_dither_gain;
   logic [DC_DITHER_W-1:0]    o_left_primary_dc_dither;
   logic [DC_DITHER_W-1:0]    o_right_primary_dc_dither;
   logic [MOD_W-1:0]          o_left_mod_lower_dithered;
   logic [MOD_W-1:0]          o_right_mod_lower_dithered;
   int                        fail_count             = 0;
   int                        n_checks               = 0;
   int                        cycles                 = 0;
   int                        seed                   = 68;
   logic [7:0]                addrs [5];
   logic [7:0]                d [5];
   logic [7:0]                junk;
   logic [10:0]               exp_l;
   logic [10:0]               exp_r;

   amdc_config #(.MOD_W(MOD_W)) dut (
      .i_ref_clk                       (i_ref_clk),
      .i_nrst                          (i_nrst),
      .i_reg_addr                      (i_reg_addr),
      .i_reg_wr                        (i_reg_wr),
      .i_reg_rd                        (i_reg_rd),
      .i_reg_wdata                     (i_reg_wdata),
      .o_reg_rdata                     (o_reg_rdata),
      .i_left_zero_qualified           (i_left_zero_qualified),
      .i_right_zero_qualified          (i_right_zero_qualified),
      .o_left_auto_mute                (o_left_auto_mute),
      .o_right_auto_mute               (o_right_auto_mute),
      .o_left_primary_ac_dither_gain   (o_left_primary_ac_dither_gain),
      .o_right_primary_ac_dither_gain  (o_right_primary_ac_dither_gain),
      .o_left_primary_dem_dither_gain  (o_left_primary_dem_dither_gain),
      .o_right_primary_dem_dither_gain (o_right_primary_dem_dither_gain),
      .i_right_dc_dither_high          (i_right_dc_dither_high),
      .o_left_primary_dc_dither        (o_left_primary_dc_dither),
      .o_right_primary_dc_dither       (o_right_primary_dc_dither),
      .i_left_mod_lower                (i_left_mod_lower),
      .i_right_mod_lower               (i_right_mod_lower),
      .o_left_mod_lower_dithered       (o_left_mod_lower_dithered),
      .o_right_mod_lower_dithered      (o_right_mod_lower_dithered)
   );

   // free running clock
   always #2 i_ref_clk = ~i_ref_clk;

   // end of run verdict
   task automatic tally_and_finish();
      if (fail_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // compare of register read data
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("MISMATCH t=%0t rdata=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask

   // compare of derived outputs
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask

   // one write strobe, then a gap cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge i_ref_clk);
      i_reg_addr  = a;
      i_reg_wdata = v;
      i_reg_wr    = 1'b1;
      @(negedge i_ref_clk);
      i_reg_wr    = 1'b0;
   endtask

   // one read strobe, data checked a cycle later
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge i_ref_clk);
      i_reg_addr = a;
      i_reg_rd   = 1'b1;
      @(negedge i_ref_clk);
      i_reg_rd   = 1'b0;
      chk_reg(o_reg_rdata, exp);
   endtask

   // expected {left, right} auto mute
   function automatic logic [1:0] exp_mute(input logic [2:0] c, input logic lz, input logic rz);
      logic both;
      both = c[2] & c[1] & c[0] & lz & rz;
      return c[2] ? {both, both} : {c[0] & lz, c[1] & rz};
   endfunction

   // qualifiers applied, mutes checked after settling
   task automatic mute_step(input logic [2:0] c, input logic lz, input logic rz);
      @(negedge i_ref_clk);
      i_left_zero_qualified  = lz;
      i_right_zero_qualified = rz;
      repeat (2) @(negedge i_ref_clk);
      chk_val({o_left_auto_mute, o_right_auto_mute}, exp_mute(c, lz, rz));
   endtask

   // hang guard
   always @(posedge i_ref_clk)
   begin
      cycles++;
      if (cycles >= MAX_CYCLES)
      begin
         fail_count++;
         tally_and_finish();
      end
   end

   // main sequence
   initial
   begin
      addrs = '{AUTO_MUTE_CONTROL_ADDR, PRIMARY_DITHER_GAINS_ADDR,
                LEFT_PRIMARY_DC_DITHER_HIGH_ADDR, LEFT_PRIMARY_DC_DITHER_LOW_ADDR,
                RIGHT_PRIMARY_DC_DITHER_PART_ADDR};
      repeat (20) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      i_nrst = 1'b1;
      // reset values and unmapped read
      rd(AUTO_MUTE_CONTROL_ADDR, AUTO_MUTE_CONTROL_RST);
      rd(PRIMARY_DITHER_GAINS_ADDR, PRIMARY_DITHER_GAINS_RST);
      rd(LEFT_PRIMARY_DC_DITHER_HIGH_ADDR, LEFT_PRIMARY_DC_DITHER_HIGH_RST);
      rd(LEFT_PRIMARY_DC_DITHER_LOW_ADDR, LEFT_PRIMARY_DC_DITHER_LOW_RST);
      rd(RIGHT_PRIMARY_DC_DITHER_PART_ADDR, RIGHT_PRIMARY_DC_DITHER_PART_RST);
      rd(8'h42, UNMAPPED_READ_VALUE);
      // every enable and link setting against every qualifier pair
      for (int c = 0; c < 8; c++)
      begin
         wr(AUTO_MUTE_CONTROL_ADDR, 8'(c));
         for (int q = 0; q < 4; q++)
            mute_step(3'(c), q[1], q[0]);
      end
      // random configurations, first two are hand-picked corners
      for (int k = 0; k < 40; k++)
      begin
         for (int i = 0; i < 5; i++)
            d[i] = 8'($random(seed));
         d[1] = d[1] & 8'hF5;
         i_right_dc_dither_high = 3'($random(seed));
         i_left_mod_lower       = 16'($random(seed));
         i_right_mod_lower      = 16'($random(seed));
         if (k == 0)
         begin
            d = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
            i_right_dc_dither_high = 3'h0;
         end
         if (k == 1)
         begin
            d = '{8'hFF, 8'h55, 8'hFF, 8'hFF, 8'hFF};
            i_right_dc_dither_high = 3'h7;
            i_left_mod_lower       = 16'hFFFF;
            i_right_mod_lower      = 16'hFFFE;
         end
         for (int i = 0; i < 5; i++)
            wr(addrs[i], d[i]);
         junk = 8'($random(seed));
         wr(8'h42, junk);
         wr(8'h47, junk);
         for (int i = 0; i < 5; i++)
            rd(addrs[i], d[i]);
         rd(8'h42, UNMAPPED_READ_VALUE);
         exp_l = {d[2][2:0], d[3]};
         exp_r = {i_right_dc_dither_high, d[4]};
         chk_val(o_left_primary_ac_dither_gain, d[1][7:6]);
         chk_val(o_right_primary_ac_dither_gain, d[1][5:4]);
         chk_val(o_left_primary_dem_dither_gain, d[1][3:2]);
         chk_val(o_right_primary_dem_dither_gain, d[1][1:0]);
         chk_val(o_left_primary_dc_dither, exp_l);
         chk_val(o_right_primary_dc_dither, exp_r);
         chk_val(o_left_mod_lower_dithered, i_left_mod_lower + 16'(exp_l));
         chk_val(o_right_mod_lower_dithered, i_right_mod_lower + 16'(exp_r));
         mute_step(d[0][2:0], k[0], k[1]);
      end
      tally_and_finish();
   end
endmodule // amdc_config_tb
